/* File: lvdseq_top.sv */
// Purpose: Low-voltage detector reset and interrupt sequencer
// Assumes: Comparator levels high while supply is above each threshold
// Notes: Mode straps are caught once after rstn release
//
// Decided for this implementation: strobed register access and the register addresses.

`timescale 1ns/10ps

module lvdseq_top
    import lvdseq_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic detector_mode_sel_hi,
    input wire logic detector_mode_sel_lo,
    input wire logic cmp_above_det,
    input wire logic cmp_above_high,
    input wire logic cmp_above_low,
    input wire logic por_req,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rdata,
    output logic lowvolt_reset,
    output logic internal_reset,
    output logic lowvolt_irq
);

    // ****************************************************************
    // Functions
    // ****************************************************************
    function automatic logic release_ok(input lvdseq_mode_t m,
                                        input logic det,
                                        input logic high);
        logic ok;
        ok = 1'b1;
        case (m)
            MODE_RST: ok = det;
            MODE_INT: ok = det;
            MODE_BOTH: ok = high;
            default: ok = 1'b1;
        endcase
        return ok;
    endfunction

    function automatic logic [7:0] level_init(input lvdseq_mode_t m);
        logic [7:0] v;
        v = LVL_INIT_OFF;
        case (m)
            MODE_RST: v = LVL_INIT_RST;
            MODE_INT: v = LVL_INIT_INT;
            MODE_BOTH: v = LVL_INIT_BOTH;
            default: v = LVL_INIT_OFF;
        endcase
        return v;
    endfunction

    // ****************************************************************
    // Input synchronisation and edges
    // ****************************************************************
    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync_q;
    logic [SYNC_W-1:0] rise;
    logic [SYNC_W-1:0] fall;

    assign raw_in = {por_req, cmp_above_low, cmp_above_high, cmp_above_det};
    lvdseq_sync #(.W(SYNC_W)) u_sync
    (
        .clk(clk),
        .rstn(rstn),
        .d(raw_in),
        .q(sync_q)
    );

    lvdseq_edge #(.W(SYNC_W)) u_edge
    (
        .clk(clk),
        .rstn(rstn),
        .lvl(sync_q),
        .rise(rise),
        .fall(fall)
    );

    wire above_det = sync_q[SI_DET];
    wire above_high = sync_q[SI_HIGH];
    wire above_low = sync_q[SI_LOW];
    wire por_on = sync_q[SI_POR];
    wire cross_det = rise[SI_DET] | fall[SI_DET];
    wire drop_high = fall[SI_HIGH];

    // ****************************************************************
    // Mode strap capture
    // ****************************************************************
    lvdseq_mode_t mode_r;
    logic cap_done_r;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_r <= MODE_RST;
            cap_done_r <= 1'b0;
        end
        else if (!cap_done_r)
        begin
            mode_r <= lvdseq_mode_t'({detector_mode_sel_hi,
                                       detector_mode_sel_lo});
            cap_done_r <= 1'b1;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    lvdseq_state_t state_r;
    lvdseq_state_t state_nxt;
    logic rewrite_en_r;
    logic mode_flag_r;
    logic level_flag_r;
    logic irq_set;

    wire gen_ok = ~rewrite_en_r;
    always_comb
    begin
        state_nxt = state_r;
        irq_set = 1'b0;
        case (state_r)
            ST_HOLD:
            begin
                if (cap_done_r && release_ok(mode_r, above_det, above_high))
                    state_nxt = ST_RUN;
            end
            ST_RUN:
            begin
                case (mode_r)
                    MODE_RST:
                    begin
                        if (!above_det && gen_ok)
                            state_nxt = ST_HOLD;
                    end
                    MODE_INT:
                    begin
                        if (cross_det && gen_ok)
                            irq_set = 1'b1;
                    end
                    MODE_BOTH:
                    begin
                        if (mode_flag_r && !above_high && gen_ok)
                            state_nxt = ST_HOLD;
                        else if (!above_low && gen_ok)
                            state_nxt = ST_HOLD;
                        else if (drop_high && gen_ok)
                        begin
                            irq_set = 1'b1;
                            state_nxt = ST_SAVE;
                        end
                    end
                    default: state_nxt = ST_RUN;
                endcase
            end
            ST_SAVE:
            begin
                if (gen_ok && (!above_low || (mode_flag_r && !above_high)))
                    state_nxt = ST_HOLD;
            end
            default: state_nxt = ST_HOLD;
        endcase
        // any power-on reset restarts the hold
        if (por_on)
            state_nxt = ST_HOLD;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            state_r <= ST_HOLD;
        else
            state_r <= state_nxt;
    end

    // ****************************************************************
    // Reset outputs
    // ****************************************************************
    logic lowvolt_reset_r;
    logic internal_reset_r;
    wire lvd_hold_nxt = (state_nxt == ST_HOLD) && (mode_r != MODE_OFF);
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            lowvolt_reset_r <= 1'b1;
            internal_reset_r <= 1'b1;
        end
        else
        begin
            lowvolt_reset_r <= lvd_hold_nxt & ~por_on;
            internal_reset_r <= lvd_hold_nxt | por_on;
        end
    end

    assign lowvolt_reset = lowvolt_reset_r;
    assign internal_reset = internal_reset_r;

    // ****************************************************************
    // Register decode
    // ****************************************************************
    wire sys_rst = internal_reset_r;
    wire wr_detect = wr_stb && (addr == OFS_DETECT);
    wire wr_level = wr_stb && (addr == OFS_LEVEL);
    wire wr_cause = wr_stb && (addr == OFS_CAUSE);
    wire wr_istat = wr_stb && (addr == OFS_IRQ_STAT);
    wire wr_imask = wr_stb && (addr == OFS_IRQ_MASK);
    wire [7:0] lvl_init = level_init(mode_r);
    wire cause_set = (state_r != ST_HOLD) && (state_nxt == ST_HOLD)
                     && !por_on;

    // ****************************************************************
    // Control and level select registers
    // ****************************************************************
    logic mask_r;
    logic irq_flag_r;
    logic cause_r;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rewrite_en_r <= 1'b0;
            mode_flag_r <= 1'b0;
            level_flag_r <= 1'b0;
            mask_r <= 1'b1;
        end
        else if (sys_rst)
        begin
            rewrite_en_r <= 1'b0;
            mode_flag_r <= lvl_init[B_MODE_FLAG];
            level_flag_r <= lvl_init[B_LEVEL_FLAG];
            mask_r <= 1'b1;
        end
        else
        begin
            if (wr_detect)
                rewrite_en_r <= wdata[B_REWRITE];
            if (wr_level && rewrite_en_r)
            begin
                mode_flag_r <= wdata[B_MODE_FLAG];
                level_flag_r <= wdata[B_LEVEL_FLAG];
            end
            if (wr_imask)
                mask_r <= wdata[B_IRQ];
        end
    end

    // ****************************************************************
    // Sticky flags, set wins over clear
    // ****************************************************************
    wire irq_flag_nxt = irq_set | (irq_flag_r & ~(wr_istat & wdata[B_IRQ]));
    wire cause_nxt = cause_set | (cause_r & ~(wr_cause & wdata[B_CAUSE]));
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irq_flag_r <= 1'b0;
        else if (sys_rst)
            irq_flag_r <= 1'b0;
        else
            irq_flag_r <= irq_flag_nxt;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cause_r <= 1'b0;
        else if (por_on)
            cause_r <= 1'b0;
        else
            cause_r <= cause_nxt;
    end

    assign lowvolt_irq = irq_flag_r & ~mask_r;

    // ****************************************************************
    // Read path
    // ****************************************************************
    wire cmp_below = (mode_r == MODE_BOTH)
                     ? (level_flag_r ? ~above_low : ~above_high)
                     : ~above_det;
    wire [7:0] rd_detect = {rewrite_en_r, rewrite_en_r, 5'h00, cmp_below};
    wire [7:0] rd_level = {mode_flag_r, 6'h00, level_flag_r};
    wire [7:0] rd_cause = {7'h00, cause_r};
    wire [7:0] rd_istat = {7'h00, irq_flag_r};
    wire [7:0] rd_imask = {7'h00, mask_r};
    wire [7:0] rd_word = (addr == OFS_DETECT) ? rd_detect :
                         (addr == OFS_LEVEL) ? rd_level :
                         (addr == OFS_CAUSE) ? rd_cause :
                         (addr == OFS_IRQ_STAT) ? rd_istat :
                         (addr == OFS_IRQ_MASK) ? rd_imask : RD_ZERO;
    logic [DATA_W-1:0] rdata_r;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata_r <= RD_ZERO;
        else
            rdata_r <= rd_stb ? rd_word : RD_ZERO;
    end

    assign rdata = rdata_r;

endmodule

/* File: lvdseq_pkg.sv */
// Purpose: Constants and types for the low-voltage reset/interrupt sequencer
// Assumes: 8-bit register port with a 3-bit word address
// Notes: Mode codes equal the option strap pair {sel_hi, sel_lo}

package lvdseq_pkg;

    // ****************************************************************
    // Register port geometry and offsets
    // ****************************************************************
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    localparam logic [2:0] OFS_DETECT = 3'h0;
    localparam logic [2:0] OFS_LEVEL = 3'h1;
    localparam logic [2:0] OFS_CAUSE = 3'h2;
    localparam logic [2:0] OFS_IRQ_STAT = 3'h3;
    localparam logic [2:0] OFS_IRQ_MASK = 3'h4;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int B_REWRITE = 7;
    localparam int B_OUT_MASK = 6;
    localparam int B_CMP = 0;
    localparam int B_MODE_FLAG = 7;
    localparam int B_LEVEL_FLAG = 0;
    localparam int B_CAUSE = 0;
    localparam int B_IRQ = 0;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] LVL_INIT_RST = 8'h81;
    localparam logic [7:0] LVL_INIT_INT = 8'h01;
    localparam logic [7:0] LVL_INIT_BOTH = 8'h00;
    localparam logic [7:0] LVL_INIT_OFF = 8'h00;
    localparam logic [7:0] RD_ZERO = 8'h00;

    // ****************************************************************
    // Synchroniser lanes
    // ****************************************************************
    localparam int SYNC_W = 4;
    localparam int SI_DET = 0;
    localparam int SI_HIGH = 1;
    localparam int SI_LOW = 2;
    localparam int SI_POR = 3;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_OFF = 2'h0,
        MODE_INT = 2'h1,
        MODE_BOTH = 2'h2,
        MODE_RST = 2'h3
    } lvdseq_mode_t;

    typedef enum logic [1:0] {
        ST_HOLD = 2'h0,
        ST_RUN = 2'h1,
        ST_SAVE = 2'h3
    } lvdseq_state_t;

endpackage

/* File: lvdseq_sync.sv */
// Purpose: Two-flop synchroniser for comparator and reset levels
// Assumes: Inputs are slow levels from outside the clock domain
// Notes: Stage one feeds stage two only

`timescale 1ns/10ps

module lvdseq_sync
    import lvdseq_pkg::*;
#(
    parameter int W = SYNC_W
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    // ****************************************************************
    // Per-lane double flop
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_lane
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                begin
                    meta_r[i] <= 1'b0;
                    q[i] <= 1'b0;
                end
                else
                begin
                    meta_r[i] <= d[i];
                    q[i] <= meta_r[i];
                end
            end
        end
    endgenerate

endmodule

/* File: lvdseq_edge.sv */
// Purpose: Rise and fall pulse detection on synchronised levels
// Assumes: Inputs already in the clk domain
// Notes: Pulses last one cycle

`timescale 1ns/10ps

module lvdseq_edge
    import lvdseq_pkg::*;
#(
    parameter int W = SYNC_W
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [W-1:0] lvl,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);

    logic [W-1:0] prev_r;

    // ****************************************************************
    // Edge compare per lane
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_edge
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    prev_r[i] <= 1'b0;
                else
                    prev_r[i] <= lvl[i];
            end
            assign rise[i] = lvl[i] & ~prev_r[i];
            assign fall[i] = ~lvl[i] & prev_r[i];
        end
    endgenerate

endmodule

/* File: lvdseq_props.sv */
// Purpose: Port checks for the low-voltage sequencer
// Assumes: Straps change only while rstn is low
// Notes: Bound to lvdseq_top below

`timescale 1ns/10ps

module lvdseq_props
    import lvdseq_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic detector_mode_sel_hi,
    input wire logic detector_mode_sel_lo,
    input wire logic cmp_above_det,
    input wire logic cmp_above_high,
    input wire logic cmp_above_low,
    input wire logic por_req,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic lowvolt_reset,
    input wire logic internal_reset,
    input wire logic lowvolt_irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    wire rst_md = detector_mode_sel_hi && detector_mode_sel_lo;
    wire int_md = !detector_mode_sel_hi && detector_mode_sel_lo;
    wire dual_md = detector_mode_sel_hi && !detector_mode_sel_lo;

    a_rdata_idle_zero:
        assert property (!$past(rd_stb) |-> rdata == 8'h00)
        else $error("read data not zero outside read cycle");
    a_rst_mode_release:
        assert property ((rst_md && cmp_above_det && !por_req)[*6]
            |-> !internal_reset) else $error("reset mode hold stuck");
    a_rst_mode_drop:
        assert property ((rst_md && !cmp_above_det && !por_req)[*6]
            |-> lowvolt_reset) else $error("reset mode drop missed");
    a_int_mode_release:
        assert property ((int_md && cmp_above_det && !por_req)[*6]
            |-> !internal_reset) else $error("interrupt mode hold stuck");
    a_dual_mode_release:
        assert property ((dual_md && cmp_above_high && cmp_above_low
            && !por_req)[*6] |-> !internal_reset)
        else $error("dual mode hold stuck");
    a_dual_low_reset:
        assert property ((dual_md && !cmp_above_low && !por_req)[*6]
            |-> lowvolt_reset) else $error("dual mode low drop missed");
    a_lvr_in_internal:
        assert property (lowvolt_reset |-> internal_reset)
        else $error("low-voltage reset not in internal reset");
    a_por_to_internal:
        assert property (por_req[*5] |-> internal_reset && !lowvolt_reset)
        else $error("power-on reset not forwarded");
    a_reset_masks_irq:
        assert property (internal_reset |=> !lowvolt_irq)
        else $error("interrupt seen after reset");

    cover property ($rose(lowvolt_irq));
    cover property ($rose(lowvolt_reset));
    cover property (por_req ##1 internal_reset);
endmodule

bind lvdseq_top lvdseq_props u_props (
    .clk(clk), .rstn(rstn),
    .detector_mode_sel_hi(detector_mode_sel_hi),
    .detector_mode_sel_lo(detector_mode_sel_lo),
    .cmp_above_det(cmp_above_det), .cmp_above_high(cmp_above_high),
    .cmp_above_low(cmp_above_low), .por_req(por_req),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .lowvolt_reset(lowvolt_reset),
    .internal_reset(internal_reset), .lowvolt_irq(lowvolt_irq)
);

/* File: lvdseq_cpu.sv */
// Purpose: Software model driving the register port
// Assumes: Called from the bench at a rising edge
// Notes: Stabilization wait is counted in system clocks

`timescale 1ns/10ps

module lvdseq_cpu
    import lvdseq_pkg::*;
#(
    parameter int STAB_CYC = 20
)
(
    input wire logic clk,
    input wire logic [DATA_W-1:0] rdata,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] wdata,
    output logic wr_stb,
    output logic rd_stb
);
    initial
    begin
        addr = 3'h0;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        wdata <= ~d;
    endtask

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    task automatic stabilize();
        wr(OFS_DETECT, 8'h80);
        repeat (STAB_CYC) @(posedge clk);
        wr(OFS_LEVEL, 8'h00);
        wr(OFS_DETECT, 8'h00);
    endtask
endmodule

/* File: lvdseq_top_tb.sv */
// Purpose: Self-checking bench for the low-voltage sequencer
// Assumes: Comparator pins are driven as slow levels
// Notes: Random register traffic from a fixed xorshift seed

`timescale 1ns/10ps

module lvdseq_top_tb
    import lvdseq_pkg::*;
;
    logic clk = 1'b0;
    logic rstn, sel_hi, sel_lo, det, high, low, por;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, v;
    logic wr_stb, rd_stb, lowvolt_reset, internal_reset, lowvolt_irq;
    logic [31:0] seed = 32'hE0923DFE;
    int mismatches = 0;
    int n_checks = 0;

    always #10 clk = ~clk;

    lvdseq_top u_dut (
        .clk(clk), .rstn(rstn), .detector_mode_sel_hi(sel_hi),
        .detector_mode_sel_lo(sel_lo), .cmp_above_det(det),
        .cmp_above_high(high), .cmp_above_low(low), .por_req(por),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .lowvolt_reset(lowvolt_reset),
        .internal_reset(internal_reset), .lowvolt_irq(lowvolt_irq)
    );
    lvdseq_cpu #(.STAB_CYC(20)) u_cpu (
        .clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb)
    );

    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    // Reset-mode read value: level select holds its start value
    function automatic logic [7:0] exp_rd(input logic [2:0] a);
        return (a == OFS_LEVEL) ? 8'h81 : 8'h00;
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_cpu.rd(a, d);
        check(d, exp);
    endtask

    // Sel 0 internal reset, 1 low-voltage reset, 2 interrupt
    task automatic wait_lvl(input int sel, input logic val);
        logic s;
        for (int i = 0; i < 40; i++)
        begin
            s = sel == 0 ? internal_reset :
                (sel == 1 ? lowvolt_reset : lowvolt_irq);
            if (s === val)
                return;
            @(posedge clk);
        end
        mismatches++;
        $display("Error at %0t: wait ran out", $time);
        results();
    endtask

    task automatic boot(input logic [1:0] md, input logic up);
        rstn <= 1'b0;
        {sel_hi, sel_lo} <= md;
        det <= up;
        high <= up;
        low <= up;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
    endtask

    initial
    begin
        rstn = 1'b0;
        {sel_hi, sel_lo, det, high, low, por} = 6'h00;
        @(posedge clk);
        boot(2'h3, 1'b1);
        wait_lvl(0, 1'b0);
        rchk(OFS_LEVEL, 8'h81);
        rchk(OFS_DETECT, 8'h00);
        rchk(OFS_CAUSE, 8'h00);
        for (int i = 0; i < 24; i++)
        begin
            seed = xs(seed);
            if (seed[3])
                u_cpu.wr(seed[2:0], seed[15:8] & 8'h7F);
            else if (seed[2:0] == OFS_LEVEL || seed[2:0] > OFS_IRQ_MASK)
                rchk(seed[2:0], exp_rd(seed[2:0]));
        end
        det <= 1'b0;
        wait_lvl(1, 1'b1);
        check(8'(internal_reset), 8'h01);
        det <= 1'b1;
        wait_lvl(0, 1'b0);
        rchk(OFS_CAUSE, 8'h01);
        u_cpu.wr(OFS_CAUSE, 8'h01);
        rchk(OFS_CAUSE, 8'h00);
        check(8'(lowvolt_irq), 8'h00);
        $display("reset mode test done");

        boot(2'h1, 1'b0);
        for (int i = 0; i < 10; i++)
        begin
            @(posedge clk);
            check(8'(internal_reset), 8'h01);
        end
        det <= 1'b1;
        wait_lvl(0, 1'b0);
        rchk(OFS_LEVEL, 8'h01);
        u_cpu.wr(OFS_IRQ_MASK, 8'h00);
        det <= 1'b0;
        wait_lvl(2, 1'b1);
        check(8'(lowvolt_reset), 8'h00);
        u_cpu.wr(OFS_IRQ_STAT, 8'h01);
        wait_lvl(2, 1'b0);
        u_cpu.wr(OFS_IRQ_MASK, 8'h01);
        det <= 1'b1;
        repeat (8) @(posedge clk);
        check(8'(lowvolt_irq), 8'h00);
        rchk(OFS_IRQ_STAT, 8'h01);
        $display("interrupt mode test done");

        boot(2'h2, 1'b1);
        wait_lvl(0, 1'b0);
        rchk(OFS_LEVEL, 8'h00);
        u_cpu.stabilize();
        u_cpu.wr(OFS_IRQ_MASK, 8'h00);
        u_cpu.wr(OFS_DETECT, 8'h80);
        high <= 1'b0;
        repeat (8) @(posedge clk);
        rchk(OFS_IRQ_STAT, 8'h00);
        check(8'(lowvolt_reset), 8'h00);
        u_cpu.wr(OFS_LEVEL, 8'h80);
        u_cpu.wr(OFS_DETECT, 8'h00);
        wait_lvl(1, 1'b1);
        high <= 1'b1;
        wait_lvl(0, 1'b0);
        rchk(OFS_CAUSE, 8'h01);
        rchk(OFS_IRQ_MASK, 8'h01);
        u_cpu.stabilize();
        u_cpu.wr(OFS_IRQ_MASK, 8'h00);
        high <= 1'b0;
        wait_lvl(2, 1'b1);
        check(8'(lowvolt_reset), 8'h00);
        u_cpu.wr(OFS_IRQ_STAT, 8'h01);
        high <= 1'b1;
        repeat (8) @(posedge clk);
        rchk(OFS_IRQ_STAT, 8'h00);
        high <= 1'b0;
        repeat (8) @(posedge clk);
        rchk(OFS_IRQ_STAT, 8'h00);
        check(8'(lowvolt_reset), 8'h00);
        low <= 1'b0;
        wait_lvl(1, 1'b1);
        $display("dual mode test done");

        por <= 1'b1;
        repeat (6) @(posedge clk);
        check(8'(internal_reset), 8'h01);
        check(8'(lowvolt_reset), 8'h00);
        por <= 1'b0;
        high <= 1'b1;
        low <= 1'b1;
        wait_lvl(0, 1'b0);
        rchk(OFS_CAUSE, 8'h00);
        check(8'(lowvolt_irq), 8'h00);
        $display("power-on test done");

        boot(2'h0, 1'b0);
        wait_lvl(0, 1'b0);
        check(8'(lowvolt_reset), 8'h00);
        rchk(OFS_DETECT, 8'h01);
        $display("off mode test done");
        results();
    end
endmodule
